// ==== src/ldw_loop_detect_watchdog.sv ====
// Loop-detect watchdog: write-once mode register, keyed restart register and overflow counter.
// Assumes slow and system count enables are one-cycle pulses from core_clk dividers, and that
// the bus marks single-bit modify accesses with busBitOp.
// How it works
// [R1] Mode register resets to 67H: longest period, slow clock selected.
// [R2] Only the first mode write after reset lands; later writes request reset.
// [R3] Bits 4:3 pick slow clock (00), system clock (01), or stop (1x).
// [R4] Bits 2:0 give period 2^(11+n) slow or 2^(13+n) system ticks.
// [R5] Overflow field reads 111 right after reset release.
// [R6] Non-stoppable option ignores clock-select writes and always counts slow ticks.
// [R7] Software writes bits 7:5 as 0,1,1.
// [R8] After a stopping first write, illegal accesses raise no reset.
// [R9] Software writes the mode register with whole-byte stores only.
// [R10] Writing ACH to restart clears the counter; counting continues.
// [R11] Restart write of any value but ACH requests reset.
// [R12] Bit-modify access to restart register requests reset.
// [R13] Restart register always reads 9AH.
// [R14] Overflow reset raises the reset-cause flag output.
// [R15] Any mode write clears the counter immediately.
// [R16] A bus qualifier marks single-bit modify accesses.
// [R17] Reaching the period gives a one-cycle reset request; stopped holds.
`timescale 1ns/1ps
`default_nettype none
module ldw_loop_detect_watchdog #(
  parameter int CNT_W = ldw_pkg::CNT_W
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        slowTick,
  input  wire logic        sysTick,
  input  wire logic        slowNoStop,
  input  wire logic [15:0] busAddr,
  input  wire logic        busWrite,
  input  wire logic        busRead,
  input  wire logic        busBitOp,
  input  wire logic [7:0]  busWdata,
  output logic      [7:0]  busRdata,
  output logic             wdtResetReq,
  output logic             wdtResetCauseFlag
);
  // Width of the period exponent, wide enough for the largest base plus the field.
  localparam int EXP_W = $clog2(ldw_pkg::SYS_BASE + 8);

  // Mode register state.
  logic [7:0]       wdtModeCtrl;
  logic [7:0]       next_wdtModeCtrl;
  logic             modeWritten;
  logic             next_modeWritten;

  // Counter state.
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;

  // Reset request and cause state.
  logic             resetReq;
  logic             next_resetReq;
  logic             causeFlag;
  logic             next_causeFlag;

  // Read data state.
  logic [7:0]       next_busRdata;

  // Decoded access and timing terms.
  logic             modeHit;
  logic             restartHit;
  logic             keyOk;
  logic             stopped;
  logic             useSysClk;
  logic             tick;
  logic             overflow;
  logic             violation;
  logic [EXP_W-1:0] periodExp;
  logic [CNT_W-1:0] period;

  // Address match, shared by the write decode and the read mux.
  function automatic logic addrIs(input logic [15:0] addr, input logic [15:0] regAddr);
    return addr == regAddr;
  endfunction : addrIs

  assign modeHit    = busWrite && addrIs(busAddr, ldw_pkg::ADDR_MODE);
  assign restartHit = busWrite && addrIs(busAddr, ldw_pkg::ADDR_RESTART);
  // A restart counts only as a whole-byte store of the key.
  assign keyOk      = busWdata == ldw_pkg::RESTART_KEY && !busBitOp; // see [R10] [R16]
  assign stopped    = wdtModeCtrl[ldw_pkg::CLK_SEL_HI]; // see [R3]
  assign useSysClk  = wdtModeCtrl[ldw_pkg::CLK_SEL_LO];
  assign tick       = useSysClk ? sysTick : slowTick; // see [R3]

  // Period minus one, so overflow fires on the tick that completes the period.
  assign periodExp  = (useSysClk ? EXP_W'(ldw_pkg::SYS_BASE) : EXP_W'(ldw_pkg::SLOW_BASE))
                      + EXP_W'(wdtModeCtrl[ldw_pkg::OVF_MSB:0]); // see [R4]
  assign period     = (CNT_W'(1) << periodExp) - CNT_W'(1); // see [R4]
  assign overflow   = !stopped && tick && count == period; // see [R17]

  // Illegal accesses only count while the dog is running.
  assign violation  = !stopped && ((modeHit && modeWritten) // see [R2] [R8]
                      || (restartHit && busBitOp) // see [R12] [R16]
                      || (restartHit && busWdata != ldw_pkg::RESTART_KEY)); // see [R11]

  // Mode register: only the first write after reset lands.
  always_comb begin
    next_wdtModeCtrl = wdtModeCtrl;
    next_modeWritten = modeWritten;
    if (modeHit && !modeWritten) begin // see [R2]
      next_modeWritten = 1'b1;
      // Fixed upper bits kept at their reset pattern.
      next_wdtModeCtrl = (ldw_pkg::MODE_RESET & ldw_pkg::FIXED_MASK) | (busWdata & ~ldw_pkg::FIXED_MASK);
      if (slowNoStop) begin // see [R6]
        next_wdtModeCtrl[ldw_pkg::CLK_SEL_HI] = 1'b0;
        next_wdtModeCtrl[ldw_pkg::CLK_SEL_LO] = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdtModeCtrl <= ldw_pkg::MODE_RESET; // see [R1] [R5]
      modeWritten <= 1'b0;
    end else begin
      wdtModeCtrl <= next_wdtModeCtrl;
      modeWritten <= next_modeWritten;
    end
  end

  // Counter: cleared by any mode write, a valid key or an overflow; held while stopped.
  always_comb begin
    next_count = count;
    if (modeHit || (restartHit && keyOk) || overflow) begin
      next_count = '0; // see [R10] [R15]
    end else if (!stopped && tick) begin
      next_count = count + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // Reset request pulses for one cycle; the cause flag stays until the next reset.
  always_comb begin
    next_resetReq  = overflow || violation; // see [R17]
    next_causeFlag = causeFlag || overflow; // see [R14]
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      resetReq  <= 1'b0;
      causeFlag <= 1'b0;
    end else begin
      resetReq  <= next_resetReq;
      causeFlag <= next_causeFlag;
    end
  end

  // Read data is registered and holds between reads; unmapped addresses read zero.
  always_comb begin
    next_busRdata = busRdata;
    if (busRead) begin
      if (addrIs(busAddr, ldw_pkg::ADDR_MODE)) begin
        next_busRdata = wdtModeCtrl;
      end else if (addrIs(busAddr, ldw_pkg::ADDR_RESTART)) begin
        next_busRdata = ldw_pkg::RESTART_READ; // see [R13]
      end else begin
        next_busRdata = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busRdata <= '0;
    end else begin
      busRdata <= next_busRdata;
    end
  end

  assign wdtResetReq       = resetReq;
  assign wdtResetCauseFlag = causeFlag;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_second_mode_write: assert property (modeHit && modeWritten && !stopped |=> wdtResetReq) // see [R2]
    else $error("second mode write did not request reset");

  a_mode_write_once: assert property (modeWritten |=> $stable(wdtModeCtrl)) // see [R2]
    else $error("mode register changed after its single write");

  a_bad_key_reset: assert property (restartHit && busWdata != ldw_pkg::RESTART_KEY && !stopped |=> wdtResetReq) // see [R11]
    else $error("wrong key did not request reset");

  a_bitop_reset: assert property (restartHit && busBitOp && !stopped |=> wdtResetReq) // see [R12]
    else $error("bit access to restart did not request reset");

  a_stopped_silent: assert property (stopped |=> !wdtResetReq) // see [R8] [R17]
    else $error("stopped watchdog requested reset");

  a_key_clears: assert property (restartHit && busWdata == ldw_pkg::RESTART_KEY && !busBitOp |=> count == '0) // see [R10]
    else $error("key did not clear counter");

  a_mode_clears: assert property (modeHit |=> count == '0) // see [R15]
    else $error("mode write did not clear counter");

  a_restart_reads: assert property (busRead && busAddr == ldw_pkg::ADDR_RESTART |=> busRdata == ldw_pkg::RESTART_READ) // see [R13]
    else $error("restart register read wrong value");

  a_noStop_slow: assert property (slowNoStop |-> !modeWritten || (!wdtModeCtrl[ldw_pkg::CLK_SEL_HI] && !wdtModeCtrl[ldw_pkg::CLK_SEL_LO])) // see [R6]
    else $error("clock select changed while slow oscillator fixed");

  a_ovf_pulse: assert property (overflow |=> wdtResetReq && wdtResetCauseFlag) // see [R14] [R17]
    else $error("overflow not signalled");

  a_cause_sticky: assert property (wdtResetCauseFlag |=> wdtResetCauseFlag) // see [R14]
    else $error("reset cause flag dropped before reset");

  // Main scenarios: keyed restart, overflow, stopping write, second write, system clock.
  c_restart_ok: cover property (restartHit && busWdata == ldw_pkg::RESTART_KEY);
  c_overflow:   cover property (overflow);
  c_stop_mode:  cover property (modeHit && busWdata[ldw_pkg::CLK_SEL_HI]);
  c_second:     cover property (modeHit && modeWritten);
  c_sys_clock:  cover property (modeHit && !modeWritten && busWdata[ldw_pkg::CLK_SEL_LO]);
endmodule : ldw_loop_detect_watchdog
`default_nettype wire

// ==== src/ldw_pkg.sv ====
// Package for the loop-detect watchdog: register addresses, field layout, reset values and keys.
// Assumes a byte-wide internal peripheral bus with a 16-bit address.
package ldw_pkg;
  localparam logic [15:0] ADDR_MODE    = 16'hff48;
  localparam logic [15:0] ADDR_RESTART = 16'hff49;
  localparam logic [7:0]  MODE_RESET   = 8'h67;
  localparam logic [7:0]  RESTART_READ = 8'h9a;
  localparam logic [7:0]  RESTART_KEY  = 8'hac;
  localparam int          CLK_SEL_HI   = 4;
  localparam int          CLK_SEL_LO   = 3;
  localparam int          OVF_MSB      = 2;
  localparam int          SLOW_BASE    = 11;
  localparam int          SYS_BASE     = 13;
  localparam int          CNT_W        = 21;
  localparam logic [7:0]  FIXED_MASK   = 8'he0;
endpackage : ldw_pkg

// ==== tb/tb_loop_detect_watchdog.sv ====
// Self-checking bench for the loop-detect watchdog.
// Assumes count ticks may be driven on every core_clk cycle to keep overflow periods short.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checkCount++; if ((s) !== (e)) begin nErrors++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, s); end end
module tb_loop_detect_watchdog;
  localparam logic [15:0] AM = ldw_pkg::ADDR_MODE;
  localparam logic [15:0] AR = ldw_pkg::ADDR_RESTART;
  logic        core_clk, arst_n, slowTick, sysTick, slowNoStop, busWrite, busRead, busBitOp;
  logic [15:0] busAddr;
  logic [7:0]  busWdata, busRdata;
  logic        wdtResetReq, wdtResetCauseFlag;
  int          nErrors, checkCount, reqCnt;
  // Rows hold restart data, bit-modify qualifier and whether a reset request follows.
  logic [9:0]  rows [4] = '{{8'hac, 1'h0, 1'h0}, {8'h00, 1'h0, 1'h1}, {8'hab, 1'h0, 1'h1}, {8'hac, 1'h1, 1'h1}};
  ldw_loop_detect_watchdog i_dut (.core_clk, .arst_n, .slowTick, .sysTick, .slowNoStop, .busAddr,
    .busWrite, .busRead, .busBitOp, .busWdata, .busRdata, .wdtResetReq, .wdtResetCauseFlag);
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wdtResetReq === 1'h1) reqCnt++;
  task automatic testDone();
    $display("errors %0d checks %0d", nErrors, checkCount);
    if (nErrors == 0 && checkCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : testDone
  task automatic rst();
    #1 arst_n = 1'h0;
    repeat (5) @(posedge core_clk);
    #1 arst_n = 1'h1;
    reqCnt = 0;
  endtask : rst
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    #1 {busAddr, busWdata, busBitOp, busWrite} = {a, d, b, 1'h1};
    @(posedge core_clk);
    #1 {busWrite, busBitOp} = 2'h0;
    repeat (2) @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    #1 {busAddr, busRead} = {a, 1'h1};
    @(posedge core_clk);
    #1 busRead = 1'h0;
    `CHK("rdata", e, busRdata)
  endtask : rd
  task automatic ticks(input logic s, input logic y, input int n);
    @(posedge core_clk);
    #1 {slowTick, sysTick} = {s, y};
    repeat (n) @(posedge core_clk);
    #1 {slowTick, sysTick} = 2'h0;
    repeat (2) @(posedge core_clk);
  endtask : ticks
  initial begin
    #(30000 * 25);
    nErrors++;
    testDone();
  end
  initial begin
    {arst_n, slowTick, sysTick, slowNoStop, busWrite, busRead, busBitOp, busAddr, busWdata} = '0;
    {nErrors, checkCount, reqCnt} = '0;
    for (int i = 0; i < 4; i++) begin
      rst();
      wr(AR, rows[i][9:2], rows[i][1]);
      `CHK("keyreq", rows[i][0], reqCnt != 0)
    end
    rst();
    rd(AM, ldw_pkg::MODE_RESET);
    rd(AR, ldw_pkg::RESTART_READ);
    rd(16'hff4a, 8'h00);
    ticks(1'h1, 1'h0, 100);
    wr(AM, 8'h60, 1'h0);
    ticks(1'h1, 1'h1, 2000);
    wr(AR, ldw_pkg::RESTART_KEY, 1'h0);
    ticks(1'h1, 1'h1, 2047);
    `CHK("early", 0, reqCnt)
    ticks(1'h1, 1'h0, 1);
    `CHK("ovf", 1, reqCnt)
    `CHK("cause", 1'h1, wdtResetCauseFlag)
    rd(AM, 8'h60);
    wr(AM, 8'h61, 1'h0);
    `CHK("second", 2, reqCnt)
    rst();
    wr(AM, 8'h70, 1'h0);
    wr(AM, 8'h60, 1'h0);
    wr(AR, 8'h00, 1'h0);
    wr(AR, ldw_pkg::RESTART_KEY, 1'h1);
    ticks(1'h1, 1'h1, 2100);
    `CHK("stopped", 0, reqCnt)
    rst();
    wr(AM, 8'h68, 1'h0);
    ticks(1'h1, 1'h1, 8191);
    `CHK("sysearly", 0, reqCnt)
    ticks(1'h0, 1'h1, 1);
    `CHK("sysovf", 1, reqCnt)
    rst();
    slowNoStop = 1'h1;
    wr(AM, 8'h70, 1'h0);
    rd(AM, 8'h60);
    ticks(1'h1, 1'h0, 2048);
    `CHK("nostop", 1, reqCnt)
    testDone();
  end
endmodule : tb_loop_detect_watchdog
`default_nettype wire
